// ===== core/sdm_pkg.sv
// constants and types for the dual-mode command and limit selector
package sdm_pkg;
    localparam int VAL_W = 16;
    typedef logic signed [VAL_W-1:0] sdm_val_t;

    // mode codes of the configuration word
    localparam logic [7:0] MODE_PULSE_SPEED  = 8'h06;
    localparam logic [7:0] MODE_PULSE_TORQUE = 8'h07;
    localparam logic [7:0] MODE_SPEED_TORQUE = 8'h0a;

    typedef enum logic [1:0] {
        SDM_POSITION = 2'b00,
        SDM_SPEED    = 2'b01,
        SDM_TORQUE   = 2'b10
    } sdm_mode_e;

    // parameter port map
    localparam logic [15:0] ANALOG_PROBE_OUTPUT_SELECT_OFS = 16'h0006;
    localparam logic [15:0] ANALOG_PROBE_OUTPUT_SELECT_RST = 16'h0000;
    localparam int          PROBE_CH1_LSB                 = 0;
    localparam int          PROBE_CH2_LSB                 = 4;
    localparam logic [2:0]  PROBE_LAST_VALID              = 3'h5;

    // limit enable field positions
    localparam int LIM_SPEED_EN_BIT  = 0;
    localparam int LIM_TORQUE_EN_BIT = 1;
endpackage

// ===== core/sdm_src_if.sv
// command source selection bundle between selector and source mux
`timescale 1ns/1ns
interface sdm_src_if;
    logic [1:0]       sel;
    sdm_pkg::sdm_val_t analog;
    sdm_pkg::sdm_val_t preset1;
    sdm_pkg::sdm_val_t preset2;
    sdm_pkg::sdm_val_t preset3;
    sdm_pkg::sdm_val_t value;

    modport user (output sel, output analog, output preset1, output preset2,
                  output preset3, input value);
    modport mux  (input sel, input analog, input preset1, input preset2,
                  input preset3, output value);
endinterface

// ===== core/sdm_cmd_src.sv
// analog or preset command source multiplexer
`timescale 1ns/1ns
module sdm_cmd_src (
    sdm_src_if.mux src
);
    // both selects low takes the analog input; no zero variant in dual modes
    always_comb begin
        case (src.sel)
            2'b00:   src.value = src.analog;
            2'b01:   src.value = src.preset1;
            2'b10:   src.value = src.preset2;
            2'b11:   src.value = src.preset3;
            default: src.value = src.analog;
        endcase
    end
endmodule // sdm_cmd_src

// ===== core/sdm_mode_sel.sv
// dual-mode control selection with speed and torque limit paths
`timescale 1ns/1ns
module sdm_mode_sel (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // parameter port
    input  wire logic              par_wr,
    input  wire logic [15:0]       par_addr,
    input  wire logic [15:0]       par_wdata,
    output logic      [15:0]       par_rdata,
    // configuration
    input  wire logic [7:0]        mode_code,
    input  wire logic [1:0]        limit_enable_config,
    input  wire logic [15:0]       max_speed_clamp,
    // digital inputs
    input  wire logic              sel_speed_pos,
    input  wire logic              sel_speed_torque,
    input  wire logic              sel_torque_pos,
    input  wire logic [1:0]        speed_source_sel,
    input  wire logic [1:0]        torque_source_sel,
    // command sources
    input  wire logic [15:0]       pulse_pos_cmd,
    input  wire sdm_pkg::sdm_val_t analog_speed,
    input  wire sdm_pkg::sdm_val_t analog_torque,
    input  wire sdm_pkg::sdm_val_t speed_preset1,
    input  wire sdm_pkg::sdm_val_t speed_preset2,
    input  wire sdm_pkg::sdm_val_t speed_preset3,
    input  wire sdm_pkg::sdm_val_t torque_preset1,
    input  wire sdm_pkg::sdm_val_t torque_preset2,
    input  wire sdm_pkg::sdm_val_t torque_preset3,
    // selected mode and commands
    output sdm_pkg::sdm_mode_e     active_mode,
    output logic                   mode_code_ok,
    output logic      [15:0]       pos_cmd,
    output sdm_pkg::sdm_val_t      speed_cmd,
    output sdm_pkg::sdm_val_t      torque_cmd,
    output sdm_pkg::sdm_val_t      speed_limit,
    output logic                   speed_limit_act,
    output sdm_pkg::sdm_val_t      torque_limit,
    output logic                   torque_limit_act,
    // analog probe selection
    output logic      [2:0]        probe_ch1_sel,
    output logic      [2:0]        probe_ch2_sel,
    output logic                   probe_ch1_valid,
    output logic                   probe_ch2_valid
);
    sdm_src_if spd_src ();
    sdm_src_if trq_src ();

    sdm_cmd_src u_spd_src (
        .src (spd_src)
    );
    sdm_cmd_src u_trq_src (
        .src (trq_src)
    );

    // the limit path shares the command mux, so one pair of selects serves both
    assign spd_src.sel     = speed_source_sel;
    assign spd_src.analog  = analog_speed;
    assign spd_src.preset1 = speed_preset1;
    assign spd_src.preset2 = speed_preset2;
    assign spd_src.preset3 = speed_preset3;
    assign trq_src.sel     = torque_source_sel;
    assign trq_src.analog  = analog_torque;
    assign trq_src.preset1 = torque_preset1;
    assign trq_src.preset2 = torque_preset2;
    assign trq_src.preset3 = torque_preset3;

    // symmetric clamp to the maximum speed magnitude
    function automatic sdm_pkg::sdm_val_t clamp_speed(input sdm_pkg::sdm_val_t v,
                                                      input logic [15:0] lim);
        logic signed [16:0] pos_lim;
        logic signed [16:0] neg_lim;
        logic signed [16:0] wide;
        pos_lim = {1'b0, lim};
        neg_lim = -pos_lim;
        wide    = {v[15], v};
        if (wide > pos_lim) begin
            wide = pos_lim;
        end else if (wide < neg_lim) begin
            wide = neg_lim;
        end
        // a limit above the signed range saturates at the extreme
        if (wide > 17'sd32767) begin
            wide = 17'sd32767;
        end else if (wide < -17'sd32768) begin
            wide = -17'sd32768;
        end
        clamp_speed = wide[15:0];
    endfunction

    // codes outside the three dual modes fall back to position control
    function automatic logic is_dual_code(input logic [7:0] code);
        is_dual_code = (code == sdm_pkg::MODE_PULSE_SPEED)
                       || (code == sdm_pkg::MODE_PULSE_TORQUE)
                       || (code == sdm_pkg::MODE_SPEED_TORQUE);
    endfunction

    // probe select register
    // only the low two digits drive selects; the upper byte is kept for readback
    logic [15:0] probe_word_ff;
    logic [15:0] nxt_probe_word;

    always_comb begin
        nxt_probe_word = probe_word_ff;
        if (par_wr && par_addr == sdm_pkg::ANALOG_PROBE_OUTPUT_SELECT_OFS) begin
            nxt_probe_word = par_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            probe_word_ff <= sdm_pkg::ANALOG_PROBE_OUTPUT_SELECT_RST;
        end else begin
            probe_word_ff <= nxt_probe_word;
        end
    end

    // unmapped offsets read zero
    assign par_rdata = (par_addr == sdm_pkg::ANALOG_PROBE_OUTPUT_SELECT_OFS)
                       ? probe_word_ff : 16'h0000;

    // top bit of each digit is ignored; 6 and 7 are reserved codes
    assign probe_ch1_sel   = probe_word_ff[sdm_pkg::PROBE_CH1_LSB +: 3];
    assign probe_ch2_sel   = probe_word_ff[sdm_pkg::PROBE_CH2_LSB +: 3];
    assign probe_ch1_valid = probe_ch1_sel <= sdm_pkg::PROBE_LAST_VALID;
    assign probe_ch2_valid = probe_ch2_sel <= sdm_pkg::PROBE_LAST_VALID;

    // mode and command selection, all updated in one edge
    sdm_pkg::sdm_mode_e mode_ff;
    sdm_pkg::sdm_mode_e nxt_mode;
    logic               code_ok_ff;
    logic               nxt_code_ok;
    logic [15:0]        pos_ff;
    logic [15:0]        nxt_pos;
    sdm_pkg::sdm_val_t  spd_ff;
    sdm_pkg::sdm_val_t  nxt_spd;
    sdm_pkg::sdm_val_t  trq_ff;
    sdm_pkg::sdm_val_t  nxt_trq;
    sdm_pkg::sdm_val_t  slim_ff;
    sdm_pkg::sdm_val_t  nxt_slim;
    logic               slim_act_ff;
    logic               nxt_slim_act;
    sdm_pkg::sdm_val_t  tlim_ff;
    sdm_pkg::sdm_val_t  nxt_tlim;
    logic               tlim_act_ff;
    logic               nxt_tlim_act;

    always_comb begin
        nxt_code_ok = is_dual_code(mode_code);
        case (mode_code)
            sdm_pkg::MODE_PULSE_SPEED:
                nxt_mode = sel_speed_pos ? sdm_pkg::SDM_SPEED
                                         : sdm_pkg::SDM_POSITION;
            sdm_pkg::MODE_PULSE_TORQUE:
                nxt_mode = sel_torque_pos ? sdm_pkg::SDM_TORQUE
                                          : sdm_pkg::SDM_POSITION;
            sdm_pkg::MODE_SPEED_TORQUE:
                nxt_mode = sel_speed_torque ? sdm_pkg::SDM_TORQUE
                                            : sdm_pkg::SDM_SPEED;
            default: begin
                // other codes are not dual modes; hold the safe position mode
                nxt_mode = sdm_pkg::SDM_POSITION;
            end
        endcase

        // target holds outside position mode; a return to position mode loads the current pulse_pos_cmd
        nxt_pos = (nxt_mode == sdm_pkg::SDM_POSITION) ? pulse_pos_cmd : pos_ff;
        nxt_spd = (nxt_mode == sdm_pkg::SDM_SPEED)
                  ? clamp_speed(spd_src.value, max_speed_clamp)
                  : '0;
        nxt_trq = (nxt_mode == sdm_pkg::SDM_TORQUE) ? trq_src.value : '0;

        nxt_slim_act = (nxt_mode == sdm_pkg::SDM_TORQUE)
                       && limit_enable_config[sdm_pkg::LIM_SPEED_EN_BIT];
        // without a speed limit the clamp still bounds torque-mode speed
        nxt_slim = nxt_slim_act ? clamp_speed(spd_src.value, max_speed_clamp)
                                : clamp_speed(16'sh7fff, max_speed_clamp);

        nxt_tlim_act = (nxt_mode != sdm_pkg::SDM_TORQUE)
                       && limit_enable_config[sdm_pkg::LIM_TORQUE_EN_BIT];
        // a disabled limit reads zero so no stale torque ceiling is left behind
        nxt_tlim = nxt_tlim_act ? trq_src.value : '0;
    end

    // one register bank, so mode and commands never disagree for a cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_ff     <= sdm_pkg::SDM_POSITION;
            code_ok_ff  <= 1'b0;
            pos_ff      <= '0;
            spd_ff      <= '0;
            trq_ff      <= '0;
            slim_ff     <= '0;
            slim_act_ff <= 1'b0;
            tlim_ff     <= '0;
            tlim_act_ff <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            code_ok_ff  <= nxt_code_ok;
            pos_ff      <= nxt_pos;
            spd_ff      <= nxt_spd;
            trq_ff      <= nxt_trq;
            slim_ff     <= nxt_slim;
            slim_act_ff <= nxt_slim_act;
            tlim_ff     <= nxt_tlim;
            tlim_act_ff <= nxt_tlim_act;
        end
    end

    assign active_mode      = mode_ff;
    assign mode_code_ok     = code_ok_ff;
    assign pos_cmd          = pos_ff;
    assign speed_cmd        = spd_ff;
    assign torque_cmd       = trq_ff;
    assign speed_limit      = slim_ff;
    assign speed_limit_act  = slim_act_ff;
    assign torque_limit     = tlim_ff;
    assign torque_limit_act = tlim_act_ff;
endmodule // sdm_mode_sel

// ===== testbench/sdm_mode_sel_monitor.sv
// assertion checker for the dual-mode selector ports
`timescale 1ns/1ns
module sdm_mode_sel_monitor (
    // clock, reset and parameter port
    input wire logic clk, input wire logic rst_n, input wire logic par_wr,
    input wire logic [15:0] par_addr, input wire logic [15:0] par_wdata,
    // configuration and digital inputs
    input wire logic [7:0] mode_code, input wire logic [1:0] limit_enable_config,
    input wire logic [15:0] max_speed_clamp, input wire logic sel_speed_pos,
    input wire logic sel_speed_torque, input wire logic sel_torque_pos,
    // observed outputs
    input wire sdm_pkg::sdm_mode_e active_mode, input wire logic mode_code_ok,
    input wire sdm_pkg::sdm_val_t speed_cmd, input wire sdm_pkg::sdm_val_t torque_limit,
    input wire logic speed_limit_act, input wire logic torque_limit_act,
    input wire logic [2:0] probe_ch1_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr6;
        par_wr && par_addr == 16'h0006;
    endsequence
    a_code_ok: assert property ($past(rst_n) |-> mode_code_ok ==
        ($past(mode_code) inside {8'h06, 8'h07, 8'h0a})) else $error("mode code flag wrong");
    a_st_mode: assert property ($past(rst_n) && $past(mode_code) == 8'h0a |->
        active_mode == ($past(sel_speed_torque) ? sdm_pkg::SDM_TORQUE : sdm_pkg::SDM_SPEED))
        else $error("speed/torque mode wrong");
    a_ps_mode: assert property ($past(rst_n) && $past(mode_code) == 8'h06 |->
        active_mode == ($past(sel_speed_pos) ? sdm_pkg::SDM_SPEED : sdm_pkg::SDM_POSITION))
        else $error("position/speed mode wrong");
    a_pt_mode: assert property ($past(rst_n) && $past(mode_code) == 8'h07 |->
        active_mode == ($past(sel_torque_pos) ? sdm_pkg::SDM_TORQUE : sdm_pkg::SDM_POSITION))
        else $error("position/torque mode wrong");
    a_slim_act: assert property ($past(rst_n) |-> speed_limit_act ==
        (active_mode == sdm_pkg::SDM_TORQUE && $past(limit_enable_config[0])))
        else $error("speed limit activity wrong");
    a_tlim_act: assert property ($past(rst_n) |-> torque_limit_act ==
        (active_mode != sdm_pkg::SDM_TORQUE && $past(limit_enable_config[1])))
        else $error("torque limit activity wrong");
    a_tlim_idle: assert property (!torque_limit_act |-> torque_limit == '0)
        else $error("torque limit not zero when idle");
    a_speed_clamp: assert property ($past(rst_n) |->
        speed_cmd <= $signed({1'b0, $past(max_speed_clamp)}) &&
        speed_cmd >= -$signed({1'b0, $past(max_speed_clamp)})) else $error("speed over clamp");
    a_probe_wr: assert property (s_wr6 |=> probe_ch1_sel == $past(par_wdata[2:0]))
        else $error("probe word not stored");
endmodule // sdm_mode_sel_monitor
bind sdm_mode_sel sdm_mode_sel_monitor sdm_mode_sel_monitor_inst (.clk(clk), .rst_n(rst_n),
    .par_wr(par_wr), .par_addr(par_addr), .par_wdata(par_wdata), .mode_code(mode_code),
    .limit_enable_config(limit_enable_config), .max_speed_clamp(max_speed_clamp),
    .sel_speed_pos(sel_speed_pos), .sel_speed_torque(sel_speed_torque),
    .sel_torque_pos(sel_torque_pos), .active_mode(active_mode), .mode_code_ok(mode_code_ok),
    .speed_cmd(speed_cmd), .torque_limit(torque_limit), .speed_limit_act(speed_limit_act),
    .torque_limit_act(torque_limit_act), .probe_ch1_sel(probe_ch1_sel));

// ===== testbench/sdm_ctrl_model.sv
// motion controller model driving the selector digital inputs
`timescale 1ns/1ns
module sdm_ctrl_model (
    // requests
    input  wire logic [7:0] code,
    input  wire logic       want_alt,
    input  wire logic [1:0] spd_pick,
    input  wire logic [1:0] trq_pick,
    // digital inputs of the drive
    output logic            sel_speed_pos,
    output logic            sel_speed_torque,
    output logic            sel_torque_pos,
    output logic [1:0]      speed_source_sel,
    output logic [1:0]      torque_source_sel
);
    // only the current code's select follows the request; the others show the
    // opposite level, so a design reading the wrong pin is caught
    always_comb begin
        sel_speed_pos     = (code == sdm_pkg::MODE_PULSE_SPEED) ? want_alt : ~want_alt;
        sel_speed_torque  = (code == sdm_pkg::MODE_SPEED_TORQUE) ? want_alt : ~want_alt;
        sel_torque_pos    = (code == sdm_pkg::MODE_PULSE_TORQUE) ? want_alt : ~want_alt;
        speed_source_sel  = spd_pick;
        torque_source_sel = trq_pick;
    end
endmodule // sdm_ctrl_model

// ===== testbench/tb_sdm_mode_sel.sv
// self-checking bench for the dual-mode selector
`timescale 1ns/1ns
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_sdm_mode_sel;
    logic clk = 0, rst_n = 0, par_wr = 0, want_alt = 0, s_sp, s_st, s_tp;
    logic [15:0] par_addr = 0, par_wdata = 0, clamp = 16'h0100, pulse = 0, rdata, pos_cmd;
    logic [7:0] mode_code = 0;
    logic [1:0] lim_en = 0, spd_pick = 0, trq_pick = 0, ssel, tsel;
    sdm_pkg::sdm_val_t sp[4] = '{16'sh0050, 16'sh0200, -16'sh0300, 16'sh0010};
    sdm_pkg::sdm_val_t tq[4] = '{16'sh0011, 16'sh0022, -16'sh0033, 16'sh0044};
    sdm_pkg::sdm_mode_e mode;
    sdm_pkg::sdm_val_t spd, trq, slim, tlim;
    logic ok, sact, tact, c1v, c2v;
    logic [2:0] c1s, c2s;
    int n_mismatch = 0, num_checks = 0;
    always #2 clk = ~clk;
    sdm_ctrl_model sdm_ctrl_model_inst (.code(mode_code), .want_alt(want_alt),
        .spd_pick(spd_pick), .trq_pick(trq_pick), .sel_speed_pos(s_sp), .sel_speed_torque(s_st),
        .sel_torque_pos(s_tp), .speed_source_sel(ssel), .torque_source_sel(tsel));
    sdm_mode_sel sdm_mode_sel_inst (.clk(clk), .rst_n(rst_n), .par_wr(par_wr),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(rdata), .mode_code(mode_code),
        .limit_enable_config(lim_en), .max_speed_clamp(clamp), .sel_speed_pos(s_sp),
        .sel_speed_torque(s_st), .sel_torque_pos(s_tp), .speed_source_sel(ssel),
        .torque_source_sel(tsel), .pulse_pos_cmd(pulse), .analog_speed(sp[0]),
        .analog_torque(tq[0]), .speed_preset1(sp[1]), .speed_preset2(sp[2]),
        .speed_preset3(sp[3]), .torque_preset1(tq[1]), .torque_preset2(tq[2]),
        .torque_preset3(tq[3]), .active_mode(mode), .mode_code_ok(ok), .pos_cmd(pos_cmd),
        .speed_cmd(spd), .torque_cmd(trq), .speed_limit(slim), .speed_limit_act(sact),
        .torque_limit(tlim), .torque_limit_act(tact), .probe_ch1_sel(c1s),
        .probe_ch2_sel(c2s), .probe_ch1_valid(c1v), .probe_ch2_valid(c2v));
    task automatic tk; @(posedge clk); #1; endtask
    task automatic nd; @(negedge clk); endtask
    function automatic sdm_pkg::sdm_val_t clampv(sdm_pkg::sdm_val_t v);
        logic signed [16:0] m;
        m = $signed({1'b0, clamp});
        return (v > m) ? m[15:0] : ((v < -m) ? 16'(-m) : v);
    endfunction
    task automatic t_regs;
        nd; par_addr = 16'h0006; par_wdata = 16'h0013; par_wr = 1; tk;
        `CK("rdata", 16'h0013, rdata)
        `CK("ch1 sel", 3'h3, c1s)
        `CK("ch2 sel", 3'h1, c2s)
        `CK("ch1 ok", 1'b1, c1v)
        nd; par_wdata = 16'h0076; tk; // back-to-back write, both digits reserved
        `CK("ch1 valid", 1'b0, c1v)
        `CK("ch2 valid", 1'b0, c2v)
        nd; par_addr = 16'h0008; par_wdata = 16'hffff; tk;
        nd; par_wr = 0; #1;
        `CK("unmapped read", 16'h0000, rdata)
        nd; par_addr = 16'h0006; #1;
        `CK("word kept", 16'h0076, rdata)
    endtask
    task automatic t_st;
        for (int i = 0; i < 4; i++) begin
            nd; mode_code = 8'h0a; lim_en = 2'b11;
            want_alt = 1; trq_pick = 2'(i); spd_pick = 2'(3 - i); tk;
            `CK("st torque", sdm_pkg::SDM_TORQUE, mode)
            `CK("code ok", 1'b1, ok)
            `CK("torque cmd", tq[i], trq)
            `CK("speed limit", clampv(sp[3 - i]), slim)
            `CK("slim act", 1'b1, sact)
            nd; want_alt = 0; tk;
            `CK("st speed", sdm_pkg::SDM_SPEED, mode)
            `CK("speed cmd", clampv(sp[3 - i]), spd)
            `CK("torque idle", 16'h0000, trq)
            `CK("torque limit", tq[i], tlim)
        end
    endtask
    task automatic t_ps_pt;
        nd; mode_code = 8'h06; lim_en = 2'b00; pulse = 16'h1111; spd_pick = 1; tk;
        `CK("ps pos", sdm_pkg::SDM_POSITION, mode)
        `CK("pos cmd", 16'h1111, pos_cmd)
        `CK("tlim off", 1'b0, tact)
        nd; want_alt = 1; pulse = 16'h2222; tk;
        `CK("pos held", 16'h1111, pos_cmd)
        `CK("ps speed", clampv(sp[1]), spd)
        nd; mode_code = 8'h07; lim_en = 2'b10; trq_pick = 2'd3; tk;
        `CK("pt mode", sdm_pkg::SDM_TORQUE, mode)
        `CK("pt torque", tq[3], trq)
        `CK("slim off", 1'b0, sact)
        `CK("tlim in torque", 1'b0, tact)
        nd; want_alt = 0; tk;
        `CK("pt pos", sdm_pkg::SDM_POSITION, mode)
        `CK("slim default", clamp, slim)
        `CK("tlim on", 1'b1, tact)
        `CK("tlim value", tq[3], tlim)
    endtask
    task automatic t_bad;
        logic [7:0] codes[4] = '{8'h00, 8'h02, 8'h05, 8'h0b};
        foreach (codes[k]) begin
            nd; mode_code = codes[k]; want_alt = 1; tk;
            `CK("code flag", 1'b0, ok)
            `CK("bad mode", sdm_pkg::SDM_POSITION, mode)
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        summarize;
    end
    initial begin
        par_addr = 16'h0006;
        repeat (2) tk;
        `CK("reset word", 16'h0000, rdata)
        `CK("reset mode", sdm_pkg::SDM_POSITION, mode)
        nd; rst_n = 1;
        t_regs;
        t_st;
        t_ps_pt;
        t_bad;
        summarize;
    end
endmodule // tb_sdm_mode_sel
